// >>> verilog/scrb_defines.svh
`ifndef SCRB_DEFINES_SVH
`define SCRB_DEFINES_SVH

////////////////////////////////////////////////////////////////////////////////
// Register offsets on the command port
`define SCRB_ADDR_W 8
`define SCRB_DATA_W 8
`define SCRB_OFS_DEFL_X 8'h04
`define SCRB_OFS_DEFL_Y 8'h05
`define SCRB_OFS_FCFG_X 8'h06
`define SCRB_OFS_FCFG_Y 8'h07
`define SCRB_OFS_PART 8'h08
`define SCRB_OFS_CTL 8'h0A
`define SCRB_OFS_CFG 8'h0B

////////////////////////////////////////////////////////////////////////////////
// Reset and factory values
`define SCRB_DEVICE_CONTROL_RESET 8'h00
`define SCRB_DEVICE_CONFIG_RESET 8'h00
`define SCRB_FACTORY_CFG 8'h81
`define SCRB_INVALID_DATA 8'h00

////////////////////////////////////////////////////////////////////////////////
// Field positions in device_control
`define SCRB_CTL_KEY_MSB 7
`define SCRB_CTL_KEY_LSB 6
`define SCRB_CTL_PHASE_MSB 5
`define SCRB_CTL_PHASE_LSB 4
`define SCRB_CTL_PHASE_EN 3
`define SCRB_CTL_RSVD_MSB 2
`define SCRB_CTL_RSVD_LSB 0

////////////////////////////////////////////////////////////////////////////////
// Field positions in device_config
`define SCRB_CFG_RAW_SEL 7
`define SCRB_CFG_INIT_DONE 5
`define SCRB_CFG_OFFSET_MONITOR_ENABLE 3

////////////////////////////////////////////////////////////////////////////////
// Reset key codes and phase codes
`define SCRB_KEY_FIRST 2'h0
`define SCRB_KEY_SECOND 2'h3
`define SCRB_KEY_THIRD 2'h1
`define SCRB_KEY_READBACK 2'h0
`define SCRB_PHASE_NORMAL 2'h3

`endif

// >>> verilog/scrb_pkg.sv
`default_nettype none

package scrb_pkg;

    // Reset key tracker states, one-hot
    typedef enum logic [2:0] {
        SCRB_SEQ_IDLE = 3'h1,
        SCRB_SEQ_GOT_FIRST = 3'h2,
        SCRB_SEQ_GOT_SECOND = 3'h4
    } scrb_seq_e;

    // Tracker state
    typedef struct packed {
        scrb_seq_e state;
        logic fire;
    } scrb_seq_s;

    // Register bank state
    typedef struct packed {
        logic [2:0] ctl_rsvd;
        logic ctl_phase_en;
        logic [1:0] ctl_phase;
        logic [7:0] cfg;
        logic rsp_valid;
        logic [7:0] rsp_data;
        logic rsp_invalid;
        logic [1:0] phase_out;
        logic phase_hold;
        logic offset_monitor_enable_on;
    } scrb_bank_s;

endpackage

`default_nettype wire

// >>> verilog/scrb_reset_seq.sv
`timescale 1ns/10ps
`default_nettype none
`include "scrb_defines.svh"

module scrb_reset_seq (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Command observation
    input wire logic cmd_take_i,
    input wire logic ctl_write_i,
    input wire logic [1:0] key_i,
    // Soft reset pulse
    output logic fire_o
);

    // Registered state and its next value
    scrb_pkg::scrb_seq_s st_r;
    scrb_pkg::scrb_seq_s st_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        st_nxt = st_r;
        st_nxt.fire = 1'b0;
        // Commands during the reset pulse are dropped with the bank
        if (cmd_take_i && !st_r.fire) begin
            if (!ctl_write_i) begin
                // Any other command breaks the chain
                st_nxt.state = scrb_pkg::SCRB_SEQ_IDLE;
            end else if (key_i == `SCRB_KEY_FIRST) begin
                // A first key always opens a fresh chain
                st_nxt.state = scrb_pkg::SCRB_SEQ_GOT_FIRST;
            end else begin
                case (st_r.state)
                    scrb_pkg::SCRB_SEQ_GOT_FIRST: begin
                        // Second key must follow directly
                        if (key_i == `SCRB_KEY_SECOND) begin
                            st_nxt.state = scrb_pkg::SCRB_SEQ_GOT_SECOND;
                        end else begin
                            st_nxt.state = scrb_pkg::SCRB_SEQ_IDLE;
                        end
                    end
                    scrb_pkg::SCRB_SEQ_GOT_SECOND: begin
                        // Third key fires, anything else restarts
                        if (key_i == `SCRB_KEY_THIRD) begin
                            st_nxt.fire = 1'b1;
                        end
                        st_nxt.state = scrb_pkg::SCRB_SEQ_IDLE;
                    end
                    default: begin
                        // Idle: out of order keys are ignored
                        st_nxt.state = scrb_pkg::SCRB_SEQ_IDLE;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            st_r.state <= scrb_pkg::SCRB_SEQ_IDLE;
            st_r.fire <= 1'b0;
        end else if (ce_i) begin
            st_r <= st_nxt;
        end
    end

    assign fire_o = st_r.fire;

    // Fire only after a completed key chain
    key_chain_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        $rose(st_r.fire) |-> $past(st_r.state) == scrb_pkg::SCRB_SEQ_GOT_SECOND
            && $past(key_i) == `SCRB_KEY_THIRD && $past(ctl_write_i))
        else $error("reset fired without full key chain");

    // Foreign command clears the chain
    chain_break_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        ce_i && cmd_take_i && !ctl_write_i && !st_r.fire
            |=> st_r.state == scrb_pkg::SCRB_SEQ_IDLE && !st_r.fire)
        else $error("key chain survived a foreign command");

endmodule

`default_nettype wire

// >>> verilog/scrb_factory_rom.sv
`timescale 1ns/10ps
`default_nettype none
`include "scrb_defines.svh"

module scrb_factory_rom #(
    parameter logic [7:0] DEFL_X = 8'h80,
    parameter logic [7:0] DEFL_Y = 8'h80,
    // Arbitrary neutral value
    parameter logic [7:0] PART_CODE = 8'h5A
) (
    // Lookup
    input wire logic [7:0] addr_i,
    output logic [7:0] data_o,
    output logic hit_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Fixed factory contents; no write path exists at all
    always_comb begin
        hit_o = 1'b1;
        case (addr_i)
            `SCRB_OFS_DEFL_X: data_o = DEFL_X;
            `SCRB_OFS_DEFL_Y: data_o = DEFL_Y;
            `SCRB_OFS_FCFG_X: data_o = `SCRB_FACTORY_CFG;
            `SCRB_OFS_FCFG_Y: data_o = `SCRB_FACTORY_CFG;
            `SCRB_OFS_PART: data_o = PART_CODE;
            default: begin
                data_o = `SCRB_INVALID_DATA;
                hit_o = 1'b0;
            end
        endcase
    end

endmodule

`default_nettype wire

// >>> verilog/scrb_register_bank.sv
`timescale 1ns/10ps
`default_nettype none
`include "scrb_defines.svh"

module scrb_register_bank #(
    parameter logic [7:0] DEFL_X = 8'h80,
    parameter logic [7:0] DEFL_Y = 8'h80,
    // Arbitrary neutral value
    parameter logic [7:0] PART_CODE = 8'h5A
) (
    // Clock, reset, enable
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,

    // Register command from the serial front end
    input wire logic cmd_valid_i,
    input wire logic cmd_write_i,
    input wire logic [7:0] cmd_addr_i,
    input wire logic [7:0] cmd_wdata_i,

    // Register response
    output logic rsp_valid_o,
    output logic [7:0] rsp_data_o,
    output logic rsp_invalid_o,

    // Device controls
    output logic device_reset_o,
    output logic init_done_o,
    output logic [1:0] offset_cancel_phase_o,
    output logic offset_cancel_hold_o,
    output logic [7:0] device_config_o,
    output logic offset_monitor_on_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Local constants

    // Control reset image split into fields
    // Both reset paths take their fields here
    localparam logic [7:0] CTL_RST = `SCRB_DEVICE_CONTROL_RESET;

    ////////////////////////////////////////////////////////////////////////////
    // Decode helper, used for the control and configuration address matches
    // One compare so all decodes agree
    function automatic logic scrb_hit(input logic [7:0] addr, input logic [7:0] ofs);
        scrb_hit = (addr == ofs);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    // Bank state and its next value
    scrb_pkg::scrb_bank_s st_r;
    scrb_pkg::scrb_bank_s st_nxt;

    // Factory lookup result
    logic [7:0] rom_data;
    logic rom_hit;

    // Soft reset from the key tracker
    logic fire;

    // Command decode
    logic ctl_write;
    logic cfg_write;

    // Lock state, taken from the stored init flag
    logic locked;

    // Control register view with keys masked
    logic [7:0] ctl_view;

    ////////////////////////////////////////////////////////////////////////////
    // Factory read-only contents
    // Combinational; its answer is registered
    scrb_factory_rom #(
        .DEFL_X(DEFL_X),
        .DEFL_Y(DEFL_Y),
        .PART_CODE(PART_CODE)
    ) u_rom (
        .addr_i(cmd_addr_i),
        .data_o(rom_data),
        .hit_o(rom_hit)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Reset key tracker; sees every command, not only control writes
    // Key bits go in raw; the bank never stores them
    scrb_reset_seq u_seq (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .cmd_take_i(cmd_valid_i),
        .ctl_write_i(ctl_write),
        .key_i(cmd_wdata_i[`SCRB_CTL_KEY_MSB:`SCRB_CTL_KEY_LSB]),
        .fire_o(fire)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Decode
    always_comb begin
        // Write strobes, qualified by a command
        ctl_write = cmd_valid_i && cmd_write_i && scrb_hit(cmd_addr_i, `SCRB_OFS_CTL);
        cfg_write = cmd_valid_i && cmd_write_i && scrb_hit(cmd_addr_i, `SCRB_OFS_CFG);

        // Lock from the stored flag, not the byte,
        // so the write setting init lands whole
        locked = st_r.cfg[`SCRB_CFG_INIT_DONE];

        // Keys never read back; low bits show the stored value
        ctl_view = {`SCRB_KEY_READBACK, st_r.ctl_phase, st_r.ctl_phase_en,
            st_r.ctl_rsvd};
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        // Everything holds by default
        st_nxt = st_r;
        // Answer strobe lasts one cycle
        st_nxt.rsp_valid = 1'b0;
        if (cmd_valid_i) begin
            // Answer carries the value held before this command
            st_nxt.rsp_valid = 1'b1;
            st_nxt.rsp_invalid = 1'b0;
            if (rom_hit) begin
                // Factory bytes; a write here changes nothing
                st_nxt.rsp_data = rom_data;
            end else if (scrb_hit(cmd_addr_i, `SCRB_OFS_CTL)) begin
                // Keys masked, low bits as stored
                st_nxt.rsp_data = ctl_view;
            end else if (scrb_hit(cmd_addr_i, `SCRB_OFS_CFG)) begin
                // Configuration byte as stored
                st_nxt.rsp_data = st_r.cfg;
            end else begin
                // Unmapped: flagged as an invalid register request
                st_nxt.rsp_data = `SCRB_INVALID_DATA;
                st_nxt.rsp_invalid = 1'b1;
            end

            // Control low bits: open only before init completes
            // Keys themselves are never stored; the tracker consumes them
            if (ctl_write && !locked) begin
                // Phase moves only if enable was already set
                if (st_r.ctl_phase_en) begin
                    st_nxt.ctl_phase =
                        cmd_wdata_i[`SCRB_CTL_PHASE_MSB:`SCRB_CTL_PHASE_LSB];
                end

                // Enable follows any unlocked write
                st_nxt.ctl_phase_en = cmd_wdata_i[`SCRB_CTL_PHASE_EN];
                // Reserved bits stored as written; host should send zero
                st_nxt.ctl_rsvd =
                    cmd_wdata_i[`SCRB_CTL_RSVD_MSB:`SCRB_CTL_RSVD_LSB];
            end

            // Configuration: whole byte until the init flag is set
            if (cfg_write && !locked) begin
                st_nxt.cfg = cmd_wdata_i;
            end
        end

        // Effective phase; normal is forced once locked
        // Taken from next state so outputs move with it
        if (st_nxt.cfg[`SCRB_CFG_INIT_DONE]) begin
            st_nxt.phase_out = `SCRB_PHASE_NORMAL;
            st_nxt.phase_hold = 1'b0;
        end else begin
            // Hold the written phase while enable is set
            st_nxt.phase_out = st_nxt.ctl_phase;
            st_nxt.phase_hold = st_nxt.ctl_phase_en;
        end

        // Offset-cancelled output always runs the monitor
        // Raw output leaves it to its own bit
        st_nxt.offset_monitor_enable_on = st_nxt.cfg[`SCRB_CFG_OFFSET_MONITOR_ENABLE] || !st_nxt.cfg[`SCRB_CFG_RAW_SEL];
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register; soft reset waits for the enable like all state
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            // Power-on image; monitor starts on
            st_r <= '0;
            st_r.ctl_phase <= CTL_RST[5:4];
            st_r.ctl_phase_en <= CTL_RST[3];
            st_r.ctl_rsvd <= CTL_RST[2:0];
            st_r.cfg <= `SCRB_DEVICE_CONFIG_RESET;
            st_r.offset_monitor_enable_on <= 1'b1;
        end else if (ce_i) begin
            if (fire) begin
                // Internal digital reset; this also drops the init lock
                // Same image as power-on; nothing survives
                st_r <= '0;
                st_r.ctl_phase <= CTL_RST[5:4];
                st_r.ctl_phase_en <= CTL_RST[3];
                st_r.ctl_rsvd <= CTL_RST[2:0];
                st_r.cfg <= `SCRB_DEVICE_CONFIG_RESET;
                st_r.offset_monitor_enable_on <= 1'b1;
            end else begin
                // Normal advance
                st_r <= st_nxt;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs, all straight from flops
    // Answer and its flags
    assign rsp_valid_o = st_r.rsp_valid;
    assign rsp_data_o = st_r.rsp_data;
    assign rsp_invalid_o = st_r.rsp_invalid;
    // Pulse straight from the tracker flop
    assign device_reset_o = fire;
    // Lock flag lives in the stored byte
    assign init_done_o = st_r.cfg[`SCRB_CFG_INIT_DONE];
    assign offset_cancel_phase_o = st_r.phase_out;
    assign offset_cancel_hold_o = st_r.phase_hold;
    assign device_config_o = st_r.cfg;
    assign offset_monitor_on_o = st_r.offset_monitor_enable_on;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    // X deflection byte reads back unchanged
    defl_x_read_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        ce_i && cmd_valid_i && !fire && cmd_addr_i == `SCRB_OFS_DEFL_X
            |=> rsp_valid_o && !rsp_invalid_o && rsp_data_o == DEFL_X)
        else $error("x deflection byte wrong");

    // Factory byte immune to a write
    fcfg_write_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        ce_i && cmd_valid_i && cmd_write_i && !fire && cmd_addr_i == `SCRB_OFS_FCFG_Y
            |=> rsp_data_o == `SCRB_FACTORY_CFG && device_config_o == $past(device_config_o))
        else $error("factory byte changed by a write");

    // Part code constant
    part_code_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        ce_i && cmd_valid_i && !fire && cmd_addr_i == `SCRB_OFS_PART
            |=> rsp_data_o == PART_CODE)
        else $error("part code wrong");

    // Control answer masks keys
    ctl_keys_zero_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        ce_i && cmd_valid_i && !fire && cmd_addr_i == `SCRB_OFS_CTL
            |=> rsp_data_o[7:6] == `SCRB_KEY_READBACK
                && rsp_data_o[5:0] == $past(ctl_view[5:0]))
        else $error("control answer shows keys or wrong low bits");

    // Locked control bits stay put
    ctl_locked_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        ce_i && ctl_write && locked && !fire
            |=> $stable(st_r.ctl_rsvd) && $stable(st_r.ctl_phase) && $stable(st_r.ctl_phase_en))
        else $error("control bits changed after init");

    // Phase gated by stored enable
    phase_gate_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        ce_i && ctl_write && !locked && !fire && !st_r.ctl_phase_en
            |=> $stable(st_r.ctl_phase))
        else $error("phase written without enable");

    // Enabled phase held on output
    phase_hold_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        !init_done_o && st_r.ctl_phase_en
            |-> offset_cancel_hold_o && offset_cancel_phase_o == st_r.ctl_phase)
        else $error("enabled phase not held");

    // Normal phase once locked
    phase_normal_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        init_done_o |-> offset_cancel_phase_o == `SCRB_PHASE_NORMAL && !offset_cancel_hold_o)
        else $error("phase not normal after init");

    // Configuration locked after init
    cfg_locked_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        ce_i && cfg_write && init_done_o && !fire |=> $stable(device_config_o))
        else $error("configuration changed after init");

    // Init flag sticky until soft reset
    init_sticky_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        init_done_o && !fire |=> init_done_o)
        else $error("init flag dropped without reset");

    // Soft reset clears the lock on the next edge
    soft_reset_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        fire && ce_i |=> !init_done_o && !rsp_valid_o && !fire)
        else $error("soft reset did not clear the bank");

    // Enable frozen once locked
    enable_frozen_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        locked && !fire |=> $stable(st_r.ctl_phase_en))
        else $error("enable bit moved after init");

    // Only soft reset reopens the byte
    cfg_frozen_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        init_done_o && !fire |=> $stable(device_config_o))
        else $error("locked configuration moved");

    // Control read leaves no chain
    read_abort_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        ce_i && cmd_valid_i && !cmd_write_i && !fire && cmd_addr_i == `SCRB_OFS_CTL
            |=> !fire ##1 !fire)
        else $error("reset fired after a control read");

    // Hold needs the stored enable
    hold_needs_en_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        offset_cancel_hold_o |-> st_r.ctl_phase_en && !init_done_o)
        else $error("phase held without enable");

    // Open configuration takes the byte
    cfg_accept_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        ce_i && cfg_write && !locked && !fire
            |=> device_config_o == $past(cmd_wdata_i))
        else $error("open configuration write lost");

    // Enabled phase write lands
    phase_accept_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        ce_i && ctl_write && !locked && !fire && st_r.ctl_phase_en
            |=> st_r.ctl_phase == $past(cmd_wdata_i[5:4]))
        else $error("enabled phase write lost");

endmodule

`default_nettype wire

// >>> dv/scrb_host_model.sv
`timescale 1ns/10ps
`default_nettype none
`include "scrb_defines.svh"

////////////////////////////////////////////////////////////////////////////////
// Host side: issues register commands the way the serial master would
module scrb_host_model (
    // Clock
    input wire logic sys_clk_i,
    // Command out
    output logic cmd_valid_o,
    output logic cmd_write_o,
    output logic [7:0] cmd_addr_o,
    output logic [7:0] cmd_wdata_o,
    // Response in
    input wire logic rsp_valid_i,
    input wire logic [7:0] rsp_data_i,
    input wire logic rsp_invalid_i
);
    // Idle bus at time zero
    initial begin
        cmd_valid_o = 1'b0;
        cmd_write_o = 1'b0;
        cmd_addr_o = 8'h00;
        cmd_wdata_o = 8'h00;
    end

    // Present one command; caller sits at a falling edge
    task automatic issue(input logic wr, input logic [7:0] addr, input logic [7:0] wd);
        cmd_valid_o = 1'b1;
        cmd_write_o = wr;
        cmd_addr_o = addr;
        // Reserved control bits always go out as zero
        cmd_wdata_o = (wr && addr == `SCRB_OFS_CTL) ? {wd[7:3], 3'h0} : wd;
    endtask

    // Full transfer: answer is sampled at the falling edge after the take edge
    task automatic cmd(input logic wr, input logic [7:0] addr, input logic [7:0] wd,
                       output logic [7:0] rd, output logic inv, output logic ok);
        issue(wr, addr, wd);
        @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        ok = rsp_valid_i;
        rd = rsp_data_i;
        inv = rsp_invalid_i;
    endtask

    // Drop the request; stale fields are inverted so nothing leans on them
    task automatic idle();
        cmd_valid_o = 1'b0;
        cmd_write_o = ~cmd_write_o;
        cmd_addr_o = ~cmd_addr_o;
        cmd_wdata_o = ~cmd_wdata_o;
        @(posedge sys_clk_i);
        @(negedge sys_clk_i);
    endtask
endmodule
`default_nettype wire

// >>> dv/test_sensor_config_register_bank.sv
`timescale 1ns/10ps
`default_nettype none
`include "scrb_defines.svh"

module test_sensor_config_register_bank;
    // Factory bytes: deflection at both code extremes, part code arbitrary
    localparam logic [7:0] DX = 8'h00;
    localparam logic [7:0] DY = 8'hFF;
    localparam logic [7:0] PC = 8'h3C;
    localparam logic [7:0] CTL = `SCRB_OFS_CTL;
    localparam logic [7:0] CFG = `SCRB_OFS_CFG;
    // Clock, reset, enable
    logic sys_clk_i;
    logic rst_i;
    logic ce_i;
    // Command and response wires
    logic cmd_valid;
    logic cmd_write;
    logic [7:0] cmd_addr;
    logic [7:0] cmd_wdata;
    logic rsp_valid;
    logic [7:0] rsp_data;
    logic rsp_invalid;
    // Device controls
    logic dev_rst;
    logic init_done;
    logic [1:0] phase;
    logic hold;
    logic [7:0] cfg;
    logic mon;
    // Bookkeeping
    int num_errors;
    int compares;
    logic [7:0] rd;
    logic inv;
    logic ok;
    logic [7:0] wd;
    logic [7:0] prev;
    logic [7:0] rom [5];
    logic [7:0] unm [4];

    ////////////////////////////////////////////////////////////////////////////
    // 40 MHz clock
    initial begin
        sys_clk_i = 1'b0;
        forever #12.5 sys_clk_i = ~sys_clk_i;
    end

    scrb_register_bank #(.DEFL_X(DX), .DEFL_Y(DY), .PART_CODE(PC)) dut (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(ce_i),
        .cmd_valid_i(cmd_valid), .cmd_write_i(cmd_write),
        .cmd_addr_i(cmd_addr), .cmd_wdata_i(cmd_wdata),
        .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data), .rsp_invalid_o(rsp_invalid),
        .device_reset_o(dev_rst), .init_done_o(init_done),
        .offset_cancel_phase_o(phase), .offset_cancel_hold_o(hold),
        .device_config_o(cfg), .offset_monitor_on_o(mon));

    scrb_host_model host (
        .sys_clk_i(sys_clk_i), .cmd_valid_o(cmd_valid), .cmd_write_o(cmd_write),
        .cmd_addr_o(cmd_addr), .cmd_wdata_o(cmd_wdata), .rsp_valid_i(rsp_valid),
        .rsp_data_i(rsp_data), .rsp_invalid_i(rsp_invalid));

    ////////////////////////////////////////////////////////////////////////////
    // Value compare
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    // Control outputs: config byte and {init, phase, hold, monitor}
    task automatic chk_outs(input logic [7:0] exp_cfg, input logic [4:0] exp_f);
        chk(cfg, exp_cfg);
        chk({3'h0, init_done, phase, hold, mon}, {3'h0, exp_f});
    endtask

    // One register access with its answer checked
    task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d,
                          input logic [7:0] exp, input logic exp_inv);
        host.cmd(wr, a, d, rd, inv, ok);
        chk({7'h0, ok}, 8'h01);
        chk(rd, exp);
        chk({7'h0, inv}, {7'h0, exp_inv});
    endtask

    // Key write after init; low control bits read back frozen at 28
    task automatic key(input logic [7:0] d, input logic exp_rst);
        access(1'b1, CTL, d, 8'h28, 1'b0);
        chk({7'h0, dev_rst}, {7'h0, exp_rst});
    endtask

    // Single exit point
    task automatic report_and_stop();
        $display("Comparisons %0d, errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Watchdog against a hung sequence
    initial begin
        repeat (3000) @(posedge sys_clk_i);
        num_errors++;
        report_and_stop();
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        num_errors = 0;
        compares = 0;
        rst_i = 1'b1;
        ce_i = 1'b1;
        rom = '{DX, DY, `SCRB_FACTORY_CFG, `SCRB_FACTORY_CFG, PC};
        unm = '{8'h03, 8'h09, 8'h0C, 8'hFF};
        repeat (2) @(negedge sys_clk_i);
        rst_i = 1'b0;
        @(negedge sys_clk_i);
        chk_outs(8'h00, 5'b0_00_0_1);
        // Frozen enable holds the command back
        ce_i = 1'b0;
        host.issue(1'b0, 8'h04, 8'h00);
        repeat (2) begin
            @(negedge sys_clk_i);
            chk({7'h0, rsp_valid}, 8'h00);
        end
        ce_i = 1'b1;
        @(negedge sys_clk_i);
        chk(rsp_data, DX);
        // Factory bytes survive host writes
        for (int i = 0; i < 5; i++) begin
            wd = 8'h04 + 8'(i);
            access(1'b0, wd, 8'h00, rom[i], 1'b0);
            access(1'b1, wd, 8'hA5, rom[i], 1'b0);
            access(1'b0, wd, 8'h00, rom[i], 1'b0);
        end
        // Unmapped places answer invalid
        for (int i = 0; i < 4; i++) begin
            access(1'b0, unm[i], 8'h00, `SCRB_INVALID_DATA, 1'b1);
            access(1'b1, unm[i], 8'h77, `SCRB_INVALID_DATA, 1'b1);
        end
        // Phase refused while enable is clear, then every code held
        access(1'b1, CTL, 8'h10, 8'h00, 1'b0);
        access(1'b1, CTL, 8'h08, 8'h00, 1'b0);
        prev = 8'h08;
        for (int p = 0; p < 4; p++) begin
            wd = {2'b00, 2'(p), 1'b1, 3'h0};
            access(1'b1, CTL, wd, prev, 1'b0);
            chk_outs(8'h00, {1'b0, 2'(p), 1'b1, 1'b1});
            prev = wd;
        end
        access(1'b1, CTL, 8'hE8, 8'h38, 1'b0);
        access(1'b0, CTL, 8'h00, 8'h28, 1'b0);
        access(1'b1, CTL, 8'h00, 8'h28, 1'b0);
        chk({7'h0, hold}, 8'h00);
        access(1'b1, CTL, 8'h08, 8'h00, 1'b0);
        access(1'b1, CTL, 8'h28, 8'h08, 1'b0);
        // Configuration writes, then init locks everything
        access(1'b1, CFG, 8'h80, 8'h00, 1'b0);
        chk_outs(8'h80, 5'b0_10_1_0);
        access(1'b1, CFG, 8'h88, 8'h80, 1'b0);
        chk_outs(8'h88, 5'b0_10_1_1);
        access(1'b1, CFG, 8'h20, 8'h88, 1'b0);
        chk_outs(8'h20, 5'b1_11_0_1);
        access(1'b1, CTL, 8'h18, 8'h28, 1'b0);
        access(1'b0, CTL, 8'h00, 8'h28, 1'b0);
        access(1'b1, CFG, 8'h00, 8'h20, 1'b0);
        access(1'b0, CFG, 8'h00, 8'h20, 1'b0);
        chk_outs(8'h20, 5'b1_11_0_1);
        // Broken key chains never reset
        key(8'h00, 1'b0);
        key(8'hC0, 1'b0);
        access(1'b0, CTL, 8'h00, 8'h28, 1'b0);
        key(8'h40, 1'b0);
        key(8'h00, 1'b0);
        key(8'h40, 1'b0);
        key(8'hC0, 1'b0);
        key(8'h00, 1'b0);
        key(8'hC0, 1'b0);
        access(1'b1, 8'h04, 8'h00, DX, 1'b0);
        key(8'h40, 1'b0);
        // Repeated first key restarts; full chain resets
        key(8'hC0, 1'b0);
        key(8'h00, 1'b0);
        key(8'h00, 1'b0);
        key(8'hC0, 1'b0);
        key(8'h40, 1'b1);
        host.idle();
        chk({7'h0, dev_rst}, 8'h00);
        chk({7'h0, rsp_valid}, 8'h00);
        chk_outs(8'h00, 5'b0_00_0_1);
        access(1'b0, CTL, 8'h00, 8'h00, 1'b0);
        access(1'b0, CFG, 8'h00, 8'h00, 1'b0);
        host.idle();
        report_and_stop();
    end
endmodule
`default_nettype wire
